// ===== logic/mfp_filt_if.sv
// Purpose: Carries the raw pin level and filter settings to the filter.
// Assumes: Single clock domain.
// Notes:   The control side drives settings, the filter returns the level.
`timescale 1ns/10ps
`include "mfp_params.svh"
interface mfp_filt_if;
    logic                   raw;
    logic                   rise_en;
    logic                   fall_en;
    logic [`MFP_CNT_W-1:0]  limit;
    logic                   level;
    modport ctl (output raw, output rise_en, output fall_en,
                 output limit, input level);
    modport flt (input raw, input rise_en, input fall_en,
                 input limit, output level);
endinterface : mfp_filt_if

// ===== logic/mfp_filter.sv
// Purpose: Per-direction debounce of the synchronised pin level.
// Assumes: limit is at least one cycle.
// Notes:   A direction with its filter off passes on the next edge.
`timescale 1ns/10ps
`include "mfp_params.svh"
module mfp_filter (
    input wire logic    clk,
    input wire logic    rst_n,
    mfp_filt_if.flt     f
);
    logic [`MFP_CNT_W-1:0]  cnt_q;
    logic                   level_q;
    logic                   dir_en;

    assign dir_en  = f.raw ? f.rise_en : f.fall_en;
    assign f.level = level_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q   <= '0;
            level_q <= 1'b0;
        end
        else if (f.raw == level_q)
            cnt_q <= '0;
        else if (!dir_en || (cnt_q >= f.limit - `MFP_CNT_W'(1)))
        begin
            level_q <= f.raw;
            cnt_q   <= '0;
        end
        else
            cnt_q <= cnt_q + `MFP_CNT_W'(1);
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_rise_held_long: assert property (
        ($rose(level_q) && $past(f.rise_en))
            |-> ($past(cnt_q) + `MFP_CNT_W'(1) >= $past(f.limit)))
        else $error("Rising edge accepted before filter time.");

    a_fall_held_long: assert property (
        ($fell(level_q) && $past(f.fall_en))
            |-> ($past(cnt_q) + `MFP_CNT_W'(1) >= $past(f.limit)))
        else $error("Falling edge accepted before filter time.");

    a_unfiltered_pass: assert property (
        (f.raw && !level_q && !f.rise_en) |=> level_q)
        else $error("Unfiltered rising edge was delayed.");

endmodule : mfp_filter

// ===== logic/mfp_params.svh
// Purpose: Offsets, field positions, reset values and timing constants.
// Assumes: 8-bit registers on the internal register port, 20 MHz clock.
// Notes:   Definitions only.
`ifndef MFP_PARAMS_SVH
`define MFP_PARAMS_SVH

`define MFP_OFS_FUNC   8'h14
`define MFP_OFS_FILT   8'h15
`define MFP_OFS_ADDR   8'ha1

`define MFP_MODE_HI    4
`define MFP_MODE_LO    1
`define MFP_DRV_BIT    0
`define MFP_FFALL_BIT  7
`define MFP_FRISE_BIT  6
`define MFP_FTIME_HI   5
`define MFP_FTIME_LO   4
`define MFP_PULL_BIT   3
`define MFP_POL_BIT    2
`define MFP_TRIG_HI    1
`define MFP_TRIG_LO    0

`define MFP_FUNC_RST   8'h00
`define MFP_FILT_RST   8'h00
`define MFP_ADDR_RST   7'h68

`define MFP_CLK_MHZ    20
`define MFP_DEB0_US    100
`define MFP_DEB1_US    1000
`define MFP_DEB2_US    10000
`define MFP_DEB3_US    100000
`define MFP_CNT_W      22

`endif

// ===== logic/mfp_pin_cfg.sv
// Purpose: Configuration and pin logic for the third multifunction pin.
// Assumes: Strap and OTP inputs are static and on the clk domain.
// Notes:   Registers sit on an 8-bit internal register port.
// How it works
// - Selector picks disabled, input, output, fixed low or fixed high.
// - Drive-type bit clear gives open-drain output, set gives push-pull.
// - Falling-edge filter bit debounces falling pin transitions.
// - Rising-edge filter bit debounces rising pin transitions.
// - Filter time code picks 100 us, 1 ms, 10 ms or 100 ms.
// - Pull bit enables pull-down on inputs, pull-up on outputs.
// - Polarity bit inverts the pin function for inputs and outputs.
// - Edge select picks both, rising, falling or no recognised edges.
// - With strap loading enabled, start-up loads pin fields from strap.
// - Seven-bit target address register defaults to 0x68.
// - A programmed OTP address replaces the default at start-up.
`timescale 1ns/10ps
`include "mfp_params.svh"
module mfp_pin_cfg #(
    parameter int unsigned DEB1_CYC = `MFP_DEB1_US * `MFP_CLK_MHZ,
    parameter int unsigned DEB2_CYC = `MFP_DEB2_US * `MFP_CLK_MHZ,
    parameter int unsigned DEB3_CYC = `MFP_DEB3_US * `MFP_CLK_MHZ
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    output logic      [7:0]    reg_rdata,
    input  wire logic          strap_load_enable,
    input  wire logic [15:0]   config_strap_pin,
    input  wire logic          otp_addr_valid,
    input  wire logic [6:0]    otp_addr,
    input  wire logic          pin_in,
    output logic               pin_out,
    output logic               pin_oe,
    output logic               pin_pull_down,
    output logic               pin_pull_up,
    input  wire logic          ch1_power_good,
    input  wire logic          ch2_power_good,
    input  wire logic          system_good,
    input  wire logic          irq_request,
    output logic               channel1_enable_in,
    output logic               channel2_enable_in,
    output logic               ch1_voltage_step_in,
    output logic               ch2_voltage_step_in,
    output logic               reload_pulse,
    output logic               pin_event,
    output logic      [6:0]    bus_target_addr
);
    localparam int unsigned DEB0_CYC = `MFP_DEB0_US * `MFP_CLK_MHZ;

    logic [1:0]             rst_sync_q;
    logic                   rst_n;
    logic                   start_q;
    logic                   pin_meta_q;
    logic                   pin_sync_q;
    logic [7:0]             func_q;
    logic [7:0]             filt_q;
    logic [6:0]             addr_q;
    logic                   lvl_prev_q;
    logic                   act_lvl;
    logic                   rise;
    logic                   fall;
    logic                   edge_ok;
    logic                   in_fn;
    logic                   out_fn;
    logic                   fn_lvl;
    logic                   drv_lvl;
    logic                   pol;
    mfp_pkg::mfp_func_e     mode;
    mfp_pkg::mfp_trig_e     trig;
    mfp_filt_if             filt_bus ();

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            start_q    <= 1'b1;
        end
        else
        begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
            start_q    <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            func_q <= `MFP_FUNC_RST;
            filt_q <= `MFP_FILT_RST;
        end
        else if (start_q)
        begin
            if (strap_load_enable)
                {filt_q, func_q} <= config_strap_pin;
        end
        else if (reg_wr && reg_addr == `MFP_OFS_FUNC)
            func_q <= reg_wdata;
        else if (reg_wr && reg_addr == `MFP_OFS_FILT)
            filt_q <= reg_wdata;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            addr_q <= `MFP_ADDR_RST;
        else if (start_q && otp_addr_valid)
            addr_q <= otp_addr;
        else if (!start_q && reg_wr && reg_addr == `MFP_OFS_ADDR)
            addr_q <= reg_wdata[6:0];
    end
    assign bus_target_addr = addr_q;

    // Unmapped offsets read as zero.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `MFP_OFS_FUNC: reg_rdata <= func_q;
                `MFP_OFS_FILT: reg_rdata <= filt_q;
                `MFP_OFS_ADDR: reg_rdata <= {1'b0, addr_q};
                default:       reg_rdata <= 8'h00;
            endcase
        end
    end

    assign mode   = mfp_pkg::mfp_func_e'(func_q[`MFP_MODE_HI:`MFP_MODE_LO]);
    assign in_fn  = mfp_pkg::is_in(mode);
    assign out_fn = mfp_pkg::is_out(mode);
    assign pol    = filt_q[`MFP_POL_BIT];
    assign trig   = mfp_pkg::mfp_trig_e'(filt_q[`MFP_TRIG_HI:`MFP_TRIG_LO]);

    function automatic logic [`MFP_CNT_W-1:0] deb_limit(input logic [1:0] s);
        unique case (s)
            2'h0: return `MFP_CNT_W'(DEB0_CYC);
            2'h1: return `MFP_CNT_W'(DEB1_CYC);
            2'h2: return `MFP_CNT_W'(DEB2_CYC);
            2'h3: return `MFP_CNT_W'(DEB3_CYC);
        endcase
    endfunction : deb_limit

    assign filt_bus.raw     = pin_sync_q;
    assign filt_bus.rise_en = filt_q[`MFP_FRISE_BIT] & in_fn;
    assign filt_bus.fall_en = filt_q[`MFP_FFALL_BIT] & in_fn;
    assign filt_bus.limit   =
        deb_limit(filt_q[`MFP_FTIME_HI:`MFP_FTIME_LO]);

    mfp_filter u_filter (
        .clk   (clk),
        .rst_n (rst_n),
        .f     (filt_bus.flt)
    );

    assign act_lvl = filt_bus.level ^ pol;
    assign rise    = act_lvl & ~lvl_prev_q;
    assign fall    = ~act_lvl & lvl_prev_q;

    assign edge_ok =
        (rise && (trig == mfp_pkg::MFP_TRIG_BOTH
                  || trig == mfp_pkg::MFP_TRIG_RISE))
        || (fall && (trig == mfp_pkg::MFP_TRIG_BOTH
                     || trig == mfp_pkg::MFP_TRIG_FALL));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lvl_prev_q          <= 1'b0;
            pin_event           <= 1'b0;
            reload_pulse        <= 1'b0;
            channel1_enable_in  <= 1'b0;
            channel2_enable_in  <= 1'b0;
            ch1_voltage_step_in <= 1'b0;
            ch2_voltage_step_in <= 1'b0;
        end
        else
        begin
            lvl_prev_q          <= act_lvl;
            pin_event           <= in_fn && edge_ok;
            reload_pulse        <= (mode == mfp_pkg::MFP_RELOAD) && edge_ok;
            channel1_enable_in  <= act_lvl && (mode == mfp_pkg::MFP_EN1
                                   || mode == mfp_pkg::MFP_EN12);
            channel2_enable_in  <= act_lvl && (mode == mfp_pkg::MFP_EN2
                                   || mode == mfp_pkg::MFP_EN12);
            ch1_voltage_step_in <= act_lvl && (mode == mfp_pkg::MFP_CH1_VOLTAGE_STEP_IN
                                   || mode == mfp_pkg::MFP_DVC12);
            ch2_voltage_step_in <= act_lvl && (mode == mfp_pkg::MFP_CH2_VOLTAGE_STEP_IN
                                   || mode == mfp_pkg::MFP_DVC12);
        end
    end

    always_comb
    begin
        unique case (mode)
            mfp_pkg::MFP_PG1:  fn_lvl = ch1_power_good;
            mfp_pkg::MFP_PG2:  fn_lvl = ch2_power_good;
            mfp_pkg::MFP_PG12: fn_lvl = ch1_power_good & ch2_power_good;
            mfp_pkg::MFP_SG:   fn_lvl = system_good;
            mfp_pkg::MFP_IRQ:  fn_lvl = irq_request;
            mfp_pkg::MFP_HIGH: fn_lvl = 1'b1;
            default:           fn_lvl = 1'b0;
        endcase
    end

    assign drv_lvl = fn_lvl ^ pol;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out       <= 1'b0;
            pin_oe        <= 1'b0;
            pin_pull_down <= 1'b0;
            pin_pull_up   <= 1'b0;
        end
        else
        begin
            pin_out       <= out_fn && func_q[`MFP_DRV_BIT] && drv_lvl;
            pin_oe        <= out_fn && (func_q[`MFP_DRV_BIT] || !drv_lvl);
            pin_pull_down <= filt_q[`MFP_PULL_BIT] && in_fn;
            pin_pull_up   <= filt_q[`MFP_PULL_BIT] && out_fn;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_addr_wr;
        !start_q && reg_wr && reg_addr == `MFP_OFS_ADDR;
    endsequence

    sequence s_addr_rd;
        !reg_wr && reg_rd && reg_addr == `MFP_OFS_ADDR;
    endsequence

    a_no_drive_off: assert property (
        !out_fn |=> !pin_oe)
        else $error("Pin driven while not an output function.");

    a_od_no_high: assert property (
        !func_q[`MFP_DRV_BIT] |=> !(pin_oe && pin_out))
        else $error("Open-drain output drove high.");

    a_pp_drives: assert property (
        (out_fn && func_q[`MFP_DRV_BIT]) |=> pin_oe)
        else $error("Push-pull output not driven.");

    a_pulls_off: assert property (
        !filt_q[`MFP_PULL_BIT] |=> !pin_pull_up && !pin_pull_down)
        else $error("Pull applied while pull bit is clear.");

    a_pull_side: assert property (
        (filt_q[`MFP_PULL_BIT] && in_fn) |=> pin_pull_down && !pin_pull_up)
        else $error("Input pin lacks pull-down.");

    a_pol_high_out: assert property (
        (mode == mfp_pkg::MFP_HIGH && func_q[`MFP_DRV_BIT])
            |=> pin_oe && (pin_out == !$past(pol)))
        else $error("High output ignores polarity.");

    a_trig_none: assert property (
        (trig == mfp_pkg::MFP_TRIG_NONE) |=> !pin_event)
        else $error("Event seen with no trigger selected.");

    a_trig_rise: assert property (
        (in_fn && rise && trig != mfp_pkg::MFP_TRIG_FALL
            && trig != mfp_pkg::MFP_TRIG_NONE) |=> pin_event)
        else $error("Rising edge not reported.");

    // The sampled reset term skips the release edge, which precedes the load.
    a_strap_load: assert property (
        (rst_n && start_q && strap_load_enable)
            |=> {filt_q, func_q} == $past(config_strap_pin))
        else $error("Strap setting not loaded at start-up.");

    a_otp_addr: assert property (
        (rst_n && start_q && otp_addr_valid) |=> addr_q == $past(otp_addr))
        else $error("OTP address not loaded.");

    a_addr_rdback: assert property (
        s_addr_wr ##1 s_addr_rd
            |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)})
        else $error("Target address read-back mismatch.");

endmodule : mfp_pin_cfg

// ===== logic/mfp_pkg.sv
// Purpose: Types and decode helpers for the multifunction pin block.
// Assumes: Function selector is 4 bits wide.
// Notes:   Codes 0 and 13 are neither input nor output.
package mfp_pkg;

    typedef enum logic [3:0] {
        MFP_DIS      = 4'h0,
        MFP_EN1      = 4'h1,
        MFP_EN2      = 4'h2,
        MFP_EN12     = 4'h3,
        MFP_CH1_VOLTAGE_STEP_IN     = 4'h4,
        MFP_CH2_VOLTAGE_STEP_IN     = 4'h5,
        MFP_DVC12    = 4'h6,
        MFP_RELOAD   = 4'h7,
        MFP_PG1      = 4'h8,
        MFP_PG2      = 4'h9,
        MFP_PG12     = 4'ha,
        MFP_SG       = 4'hb,
        MFP_IRQ      = 4'hc,
        MFP_RSVD     = 4'hd,
        MFP_LOW      = 4'he,
        MFP_HIGH     = 4'hf
    } mfp_func_e;

    typedef enum logic [1:0] {
        MFP_TRIG_BOTH = 2'h0,
        MFP_TRIG_RISE = 2'h1,
        MFP_TRIG_FALL = 2'h2,
        MFP_TRIG_NONE = 2'h3
    } mfp_trig_e;

    function automatic logic is_in(input mfp_func_e m);
        return (m >= MFP_EN1) && (m <= MFP_RELOAD);
    endfunction : is_in

    function automatic logic is_out(input mfp_func_e m);
        return ((m >= MFP_PG1) && (m <= MFP_IRQ)) || (m == MFP_LOW)
            || (m == MFP_HIGH);
    endfunction : is_out

endpackage : mfp_pkg

// ===== tb/mfp_host_model.sv
// Purpose: Host logic on the far side of the multifunction pin.
// Assumes: The host only drives the pin while the pin is an input.
// Notes:   An undriven, unpulled pin toggles every cycle.
`timescale 1ns/10ps
module mfp_host_model (
    input  wire logic clk,
    input  wire logic drive_en,
    input  wire logic drive_val,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic pin_pull_down,
    input  wire logic pin_pull_up,
    output logic      pin_level
);
    logic float_q = 1'b0;

    always_ff @(posedge clk)
    begin
        float_q <= ~float_q;
    end

    always_comb
    begin
        if (pin_oe)
            pin_level = pin_out;
        else if (drive_en)
            pin_level = drive_val;
        else if (pin_pull_up)
            pin_level = 1'b1;
        else if (pin_pull_down)
            pin_level = 1'b0;
        else
            pin_level = float_q;
    end
endmodule : mfp_host_model

// ===== tb/tb.sv
// Purpose: Self-checking bench for the multifunction pin block.
// Assumes: Short filter counts of 20, 40 and 80 cycles.
// Notes:   Inputs change on the falling clock edge.
`timescale 1ns/10ps
module tb;
    logic       clk = 1'b0;
    logic       nrst, reg_wr, reg_rd, strap_en, otp_v;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic [6:0] bus_target_addr;
    logic       pin_level, pin_out, pin_oe, pull_dn, pull_up;
    logic       pg1, pg2, sg, irq, hd_en, hd_val;
    logic       c1en, c2en, v1, v2, rld, evt;
    int         mismatches = 0;
    int         n_compared = 0;

    always #25 clk = ~clk;

    mfp_pin_cfg #(.DEB1_CYC(20), .DEB2_CYC(40), .DEB3_CYC(80)) DUT (
        .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .strap_load_enable(strap_en), .config_strap_pin(16'h081f),
        .otp_addr_valid(otp_v), .otp_addr(7'h2a), .pin_in(pin_level),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_down(pull_dn),
        .pin_pull_up(pull_up), .ch1_power_good(pg1),
        .ch2_power_good(pg2), .system_good(sg), .irq_request(irq),
        .channel1_enable_in(c1en), .channel2_enable_in(c2en),
        .ch1_voltage_step_in(v1), .ch2_voltage_step_in(v2),
        .reload_pulse(rld), .pin_event(evt),
        .bus_target_addr(bus_target_addr));

    mfp_host_model host (
        .clk(clk), .drive_en(hd_en), .drive_val(hd_val),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_down(pull_dn),
        .pin_pull_up(pull_up), .pin_level(pin_level));

    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rdr

    task automatic do_reset(input logic s, input logic o);
        @(negedge clk);
        nrst = 1'b0;
        strap_en = s;
        otp_v = o;
        cyc(12);
        nrst = 1'b1;
        cyc(4);
    endtask : do_reset

    task automatic t_startup();
        rdr(8'h14, rd);
        chk(rd, 8'h1f, "strap function reg");
        rdr(8'h15, rd);
        chk(rd, 8'h08, "strap filter reg");
        chk({1'b0, bus_target_addr}, 8'h2a, "otp address");
        chk({4'h0, pin_oe, pin_out, pull_up, pull_dn}, 8'h0e,
            "strap pin");
    endtask : t_startup

    task automatic t_regs();
        rdr(8'h14, rd);
        chk(rd, 8'h00, "function reset");
        rdr(8'ha1, rd);
        chk(rd, 8'h68, "address reset");
        wr(8'ha1, 8'h12);
        chk({1'b0, bus_target_addr}, 8'h12, "address port");
        rdr(8'ha1, rd);
        chk(rd, 8'h12, "address readback");
        wr(8'ha1, 8'hff);
        rdr(8'ha1, rd);
        chk(rd, 8'h7f, "address bit 7");
        // A write followed by a read in the very next cycle.
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = 8'ha1;
        reg_wdata = 8'h35;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(reg_rdata, 8'h35, "back-to-back read");
        wr(8'h30, 8'h55);
        rdr(8'h30, rd);
        chk(rd, 8'h00, "unmapped offset");
    endtask : t_regs

    task automatic t_outputs();
        logic [3:0] m;
        logic       f, l, off;
        logic [3:0] ml[9] = '{4'h0, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc,
                              4'hd, 4'he, 4'hf};
        pg1 = 1'b1;
        pg2 = 1'b0;
        sg = 1'b1;
        irq = 1'b1;
        for (int i = 0; i < 36; i++)
        begin
            m = ml[i / 4];
            wr(8'h15, {4'h0, 1'b1, i[1], 2'b00});
            wr(8'h14, {3'b000, m, i[0]});
            cyc(3);
            f = (m == 4'h8) ? pg1 : (m == 4'h9) ? pg2 :
                (m == 4'ha) ? (pg1 & pg2) : (m == 4'hb) ? sg :
                (m == 4'hc) ? irq : (m == 4'hf);
            l = f ^ i[1];
            off = (m == 4'h0) || (m == 4'hd);
            chk({pull_up, pull_dn}, off ? 8'h0 : 8'h2, "pulls");
            if (off)
                chk(pin_oe, 8'h0, "disabled enable");
            else if (i[0])
                chk({pin_oe, pin_out}, {7'h1, l}, "push-pull");
            else
                chk({pin_oe, pin_out}, {6'h0, !l, 1'b0},
                    "open-drain");
        end
    endtask : t_outputs

    task automatic t_inputs();
        logic [3:0] m;
        logic       a;
        hd_en = 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            m = 4'(i / 4 + 1);
            hd_val = i[0];
            wr(8'h15, {4'h0, 1'b1, i[1], 2'b00});
            wr(8'h14, {3'b000, m, 1'b0});
            cyc(6);
            a = i[0] ^ i[1];
            chk({pin_oe, pull_up, pull_dn}, 8'h1, "input pulls");
            chk({c1en, c2en, v1, v2},
                {4'h0, a & (m == 1 || m == 3), a & (m == 2 || m == 3),
                 a & (m == 4 || m == 6), a & (m == 5 || m == 6)}, "levels");
        end
    endtask : t_inputs

    task automatic t_trig();
        int nr;
        int ne;
        for (int t = 0; t < 4; t++)
        begin
            hd_val = 1'b0;
            wr(8'h15, 8'(t));
            wr(8'h14, 8'h0e);
            cyc(6);
            for (int e = 0; e < 2; e++)
            begin
                nr = 0;
                ne = 0;
                hd_val = !e[0];
                repeat (8)
                begin
                    @(negedge clk);
                    nr += (rld === 1'b1);
                    ne += (evt === 1'b1);
                end
                chk(8'(nr), 8'(t == 0 || t == e + 1),
                    "reload pulses");
                chk(8'(ne), 8'(t == 0 || t == e + 1),
                    "event pulses");
            end
        end
    endtask : t_trig

    task automatic t_filter();
        int lim[4] = '{2000, 20, 40, 80};
        for (int c = 0; c < 4; c++)
        begin
            hd_val = 1'b0;
            wr(8'h15, {2'b11, 2'(c), 4'h0});
            wr(8'h14, 8'h02);
            cyc(lim[c] + 10);
            hd_val = 1'b1;
            cyc(lim[c] / 2);
            hd_val = 1'b0;
            cyc(lim[c] + 10);
            chk(c1en, 8'h0, "short high lost");
            hd_val = 1'b1;
            cyc(lim[c] + 10);
            chk(c1en, 8'h1, "long high taken");
            hd_val = 1'b0;
            cyc(lim[c] / 2);
            hd_val = 1'b1;
            cyc(lim[c] + 10);
            chk(c1en, 8'h1, "short low lost");
            wr(8'h15, {2'b01, 2'(c), 4'h0});
            hd_val = 1'b0;
            cyc(6);
            chk(c1en, 8'h0, "unfiltered fall");
        end
    endtask : t_filter

    initial
    begin
        {nrst, reg_wr, reg_rd, strap_en, otp_v} = 5'b00000;
        {reg_addr, reg_wdata, pg1, pg2, sg, irq, hd_en, hd_val} = '0;
        do_reset(1'b1, 1'b1);
        t_startup();
        do_reset(1'b0, 1'b0);
        t_regs();
        t_outputs();
        t_inputs();
        t_trig();
        t_filter();
        wrap_up();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule : tb
